// ==== rtl/spp_ports.sv ====
// Shared parallel I/O ports B, C and D with peripheral output ownership and analog pin select.
//
// Chosen here: the strobed register port.
`timescale 1ns/10ps

module spp_ports #(
   parameter int ADDR_W = 16,
   parameter int PIN_W  = 16
) (
   input  wire logic              clock,
   input  wire logic              rst_n,
   input  wire logic [ADDR_W-1:0] reg_addr,
   input  wire logic [15:0]       reg_wdata,
   input  wire logic              reg_write,
   input  wire logic              reg_read,
   output logic      [15:0]       reg_rdata,
   input  wire logic [PIN_W-1:0]  pad_in_b,
   input  wire logic [PIN_W-1:0]  pad_in_c,
   input  wire logic [PIN_W-1:0]  pad_in_d,
   output logic      [PIN_W-1:0]  pad_out_b,
   output logic      [PIN_W-1:0]  pad_out_c,
   output logic      [PIN_W-1:0]  pad_out_d,
   output logic      [PIN_W-1:0]  pad_oe_b,
   output logic      [PIN_W-1:0]  pad_oe_c,
   output logic      [PIN_W-1:0]  pad_oe_d,
   input  wire logic [PIN_W-1:0]  periph_own_b,
   input  wire logic [PIN_W-1:0]  periph_own_c,
   input  wire logic [PIN_W-1:0]  periph_own_d,
   input  wire logic [PIN_W-1:0]  periph_out_b,
   input  wire logic [PIN_W-1:0]  periph_out_c,
   input  wire logic [PIN_W-1:0]  periph_out_d,
   input  wire logic [PIN_W-1:0]  periph_oe_b,
   input  wire logic [PIN_W-1:0]  periph_oe_c,
   input  wire logic [PIN_W-1:0]  periph_oe_d,
   output logic      [PIN_W-1:0]  converter_input_pins
);

   logic [PIN_W-1:0] dir_b;
   logic [PIN_W-1:0] dir_c;
   logic [PIN_W-1:0] dir_d;
   logic [PIN_W-1:0] lat_b;
   logic [PIN_W-1:0] lat_c;
   logic [PIN_W-1:0] lat_d;
   logic [PIN_W-1:0] analog_pin_select;
   logic [PIN_W-1:0] next_out_b;
   logic [PIN_W-1:0] next_out_c;
   logic [PIN_W-1:0] next_out_d;
   logic [PIN_W-1:0] next_oe_b;
   logic [PIN_W-1:0] next_oe_c;
   logic [PIN_W-1:0] next_oe_d;
   logic [PIN_W-1:0] pin_read_b;
   logic [15:0]      next_rdata;
   spp_pkg::spp_kind_e kind;
   logic [1:0]         port_sel;
   logic               hit_ana;
   logic [3:0]         decoded;
   logic [PIN_W-1:0]   impl_b;
   logic [PIN_W-1:0]   impl_c;
   logic [PIN_W-1:0]   impl_d;

   // Decodes an address into a register kind of one port; port_sel 0=B 1=C 2=D 3=none.
   function automatic logic [3:0] spp_decode(input logic [ADDR_W-1:0] a);
      logic [15:0] w;
      w = 16'(a);
      case (w)
         spp_pkg::OFF_B_DIR: spp_decode = {2'b00, spp_pkg::SPP_DIR};
         spp_pkg::OFF_B_PIN: spp_decode = {2'b00, spp_pkg::SPP_PIN};
         spp_pkg::OFF_B_LAT: spp_decode = {2'b00, spp_pkg::SPP_LAT};
         spp_pkg::OFF_C_DIR: spp_decode = {2'b01, spp_pkg::SPP_DIR};
         spp_pkg::OFF_C_PIN: spp_decode = {2'b01, spp_pkg::SPP_PIN};
         spp_pkg::OFF_C_LAT: spp_decode = {2'b01, spp_pkg::SPP_LAT};
         spp_pkg::OFF_D_DIR: spp_decode = {2'b10, spp_pkg::SPP_DIR};
         spp_pkg::OFF_D_PIN: spp_decode = {2'b10, spp_pkg::SPP_PIN};
         spp_pkg::OFF_D_LAT: spp_decode = {2'b10, spp_pkg::SPP_LAT};
         default:            spp_decode = {2'b11, spp_pkg::SPP_NONE};
      endcase
   endfunction : spp_decode

   // Picks the peripheral's value where it owns the pin and the port's value elsewhere.
   function automatic logic spp_pick(input logic own, input logic periph_val, input logic port_val);
      spp_pick = own ? periph_val : port_val;
   endfunction : spp_pick

   // Splits the decoded address into port and register kind.
   // The decode is held in one variable so that both fields come from a single call.
   always_comb begin
      decoded  = spp_decode(reg_addr);
      port_sel = decoded[3:2];
      kind     = spp_pkg::spp_kind_e'(decoded[1:0]);
      hit_ana  = (16'(reg_addr) == spp_pkg::OFF_ANA_SEL);
   end

   // Implemented-pin masks sized to the pin width; absent pins are never driven.
   assign impl_b = PIN_W'(spp_pkg::IMPL_B);
   assign impl_c = PIN_W'(spp_pkg::IMPL_C);
   assign impl_d = PIN_W'(spp_pkg::IMPL_D);

   // Port B direction register; every pin starts as an input so nothing fights the board.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         dir_b <= PIN_W'(spp_pkg::RST_B_DIR);
      end else if (reg_write && kind == spp_pkg::SPP_DIR && port_sel == 2'b00) begin
         dir_b <= PIN_W'(reg_wdata & spp_pkg::IMPL_B);
      end
   end

   // Port C direction register; only the implemented pins hold a bit, the rest stay zero.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         dir_c <= PIN_W'(spp_pkg::RST_C_DIR);
      end else if (reg_write && kind == spp_pkg::SPP_DIR && port_sel == 2'b01) begin
         dir_c <= PIN_W'(reg_wdata & spp_pkg::IMPL_C);
      end
   end

   // Port D direction register; every pin starts as an input.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         dir_d <= PIN_W'(spp_pkg::RST_D_DIR);
      end else if (reg_write && kind == spp_pkg::SPP_DIR && port_sel == 2'b10) begin
         dir_d <= PIN_W'(reg_wdata & spp_pkg::IMPL_D);
      end
   end

   // Port B output latch; a write to the pin-read or the latch address lands here.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         lat_b <= PIN_W'(spp_pkg::RST_LAT);
      end else if (reg_write && (kind == spp_pkg::SPP_LAT || kind == spp_pkg::SPP_PIN) && port_sel == 2'b00) begin
         lat_b <= PIN_W'(reg_wdata & spp_pkg::IMPL_B);
      end
   end

   // Port C output latch; absent pins are masked so they read back as zero.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         lat_c <= PIN_W'(spp_pkg::RST_LAT);
      end else if (reg_write && (kind == spp_pkg::SPP_LAT || kind == spp_pkg::SPP_PIN) && port_sel == 2'b01) begin
         lat_c <= PIN_W'(reg_wdata & spp_pkg::IMPL_C);
      end
   end

   // Port D output latch; it starts at zero so a later direction change drives low first.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         lat_d <= PIN_W'(spp_pkg::RST_LAT);
      end else if (reg_write && (kind == spp_pkg::SPP_LAT || kind == spp_pkg::SPP_PIN) && port_sel == 2'b10) begin
         lat_d <= PIN_W'(reg_wdata & spp_pkg::IMPL_D);
      end
   end

   // Analog pin select register; each bit stands for one converter input on port B.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         analog_pin_select <= PIN_W'(spp_pkg::RST_ANA_SEL);
      end else if (reg_write && hit_ana) begin
         analog_pin_select <= PIN_W'(reg_wdata);
      end
   end

   // Port B pin-read value with analog inputs forced to zero.
   always_comb begin
      pin_read_b = pad_in_b & PIN_W'(spp_pkg::IMPL_B) & ~(analog_pin_select & dir_b);
   end

   // Read mux; unmapped addresses read zero.
   always_comb begin
      next_rdata = 16'h0000;
      if (hit_ana) begin
         next_rdata = 16'(analog_pin_select);
      end else begin
         case ({port_sel, kind})
            {2'b00, spp_pkg::SPP_DIR}: next_rdata = 16'(dir_b);
            {2'b00, spp_pkg::SPP_PIN}: next_rdata = 16'(pin_read_b);
            {2'b00, spp_pkg::SPP_LAT}: next_rdata = 16'(lat_b);
            {2'b01, spp_pkg::SPP_DIR}: next_rdata = 16'(dir_c);
            {2'b01, spp_pkg::SPP_PIN}: next_rdata = 16'(pad_in_c) & spp_pkg::IMPL_C;
            {2'b01, spp_pkg::SPP_LAT}: next_rdata = 16'(lat_c);
            {2'b10, spp_pkg::SPP_DIR}: next_rdata = 16'(dir_d);
            {2'b10, spp_pkg::SPP_PIN}: next_rdata = 16'(pad_in_d) & spp_pkg::IMPL_D;
            {2'b10, spp_pkg::SPP_LAT}: next_rdata = 16'(lat_d);
            default:                   next_rdata = 16'h0000;
         endcase
      end
   end

   // Read data register: valid only the cycle after a read strobe.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         reg_rdata <= 16'h0000;
      end else if (reg_read) begin
         reg_rdata <= next_rdata;
      end else begin
         reg_rdata <= 16'h0000;
      end
   end

   // One pair of ownership muxes per pin and port: output data and output enable.
   // A peripheral that owns an implemented pin wins outright; an idle one hands it back to the port.
   for (genvar i = 0; i < PIN_W; i++) begin : g_pin
      // Port B pin; its enable also lets an analog pin set as output drive its level.
      always_comb begin
         next_out_b[i] = spp_pick(periph_own_b[i], periph_out_b[i], lat_b[i]);
         next_oe_b[i]  = spp_pick(periph_own_b[i], periph_oe_b[i], ~dir_b[i]) & impl_b[i];
      end
      // Port C pin; absent pins are never enabled whoever asks.
      always_comb begin
         next_out_c[i] = spp_pick(periph_own_c[i], periph_out_c[i], lat_c[i]);
         next_oe_c[i]  = spp_pick(periph_own_c[i], periph_oe_c[i], ~dir_c[i]) & impl_c[i];
      end
      // Port D pin.
      always_comb begin
         next_out_d[i] = spp_pick(periph_own_d[i], periph_out_d[i], lat_d[i]);
         next_oe_d[i]  = spp_pick(periph_own_d[i], periph_oe_d[i], ~dir_d[i]) & impl_d[i];
      end
   end : g_pin

   // Port B pad drive; registered so that a decode glitch never reaches a pad.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         pad_out_b <= '0;
         pad_oe_b  <= '0;
      end else begin
         pad_out_b <= next_out_b;
         pad_oe_b  <= next_oe_b;
      end
   end

   // Port C pad drive; released during reset so all pins float as inputs.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         pad_out_c <= '0;
         pad_oe_c  <= '0;
      end else begin
         pad_out_c <= next_out_c;
         pad_oe_c  <= next_oe_c;
      end
   end

   // Port D pad drive; the enable lags a direction write by one cycle.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         pad_out_d <= '0;
         pad_oe_d  <= '0;
      end else begin
         pad_out_d <= next_out_d;
         pad_oe_d  <= next_oe_d;
      end
   end

   // Converter feed: analog-selected port B pins only; an output pin passes its driven level.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         converter_input_pins <= '0;
      end else begin
         converter_input_pins <= analog_pin_select & pad_in_b;
      end
   end

endmodule : spp_ports

// ==== rtl/spp_pkg.sv ====
// Package with the register map, reset values and field layouts of the shared pin ports.
package spp_pkg;
   // Register offsets; printed offsets are not all multiples of four, so they are word indices.
   localparam logic [15:0] OFF_B_DIR   = 16'h02C6;
   localparam logic [15:0] OFF_B_PIN   = 16'h02C8;
   localparam logic [15:0] OFF_B_LAT   = 16'h02CB;
   localparam logic [15:0] OFF_C_DIR   = 16'h02CC;
   localparam logic [15:0] OFF_C_PIN   = 16'h02CE;
   localparam logic [15:0] OFF_C_LAT   = 16'h02D0;
   localparam logic [15:0] OFF_D_DIR   = 16'h02D2;
   localparam logic [15:0] OFF_D_PIN   = 16'h02D4;
   localparam logic [15:0] OFF_D_LAT   = 16'h02D6;
   localparam logic [15:0] OFF_ANA_SEL = 16'h02A8;
   // Reset values.
   localparam logic [15:0] RST_B_DIR   = 16'hFFFF;
   localparam logic [15:0] RST_C_DIR   = 16'hE00A;
   localparam logic [15:0] RST_D_DIR   = 16'hFFFF;
   localparam logic [15:0] RST_LAT     = 16'h0000;
   localparam logic [15:0] RST_ANA_SEL = 16'h0000;
   // Implemented pins of each port.
   localparam logic [15:0] IMPL_B      = 16'hFFFF;
   localparam logic [15:0] IMPL_C      = 16'hE00A;
   localparam logic [15:0] IMPL_D      = 16'hFFFF;
   // Register kinds within a port.
   typedef enum logic [1:0] {
      SPP_DIR  = 2'b00,
      SPP_PIN  = 2'b01,
      SPP_LAT  = 2'b10,
      SPP_NONE = 2'b11
   } spp_kind_e;
endpackage : spp_pkg

// ==== dv/spp_ports_checker.sv ====
// Concurrent checks on the shared pin port block.
`timescale 1ns/10ps
module spp_chk #(parameter int ADDR_W = 16, parameter int PIN_W = 16) (
   input wire logic              clock,
   input wire logic              rst_n,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic              reg_read,
   input wire logic [15:0]       reg_rdata,
   input wire logic [PIN_W-1:0]  pad_in_b,
   input wire logic [PIN_W-1:0]  pad_out_b,
   input wire logic [PIN_W-1:0]  pad_oe_b,
   input wire logic [PIN_W-1:0]  pad_oe_c,
   input wire logic [PIN_W-1:0]  pad_oe_d,
   input wire logic [PIN_W-1:0]  periph_own_b,
   input wire logic [PIN_W-1:0]  periph_out_b,
   input wire logic [PIN_W-1:0]  periph_oe_b,
   input wire logic [PIN_W-1:0]  periph_own_d,
   input wire logic [PIN_W-1:0]  converter_input_pins
);
   logic mapped;
   // Flags an address that names one of the registers.
   assign mapped = reg_addr inside {16'h02C6, 16'h02C8, 16'h02CB, 16'h02CC, 16'h02CE, 16'h02D0,
                                    16'h02D2, 16'h02D4, 16'h02D6, 16'h02A8};
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   a_rdata_idle: assert property (!reg_read |=> reg_rdata == 16'h0000) else $error("read data not idle");
   a_unmapped_read: assert property (reg_read && !mapped |=> reg_rdata == 16'h0000)
      else $error("unmapped read not zero");
   a_periph_data: assert property ($past(rst_n) |-> ((pad_out_b ^ $past(periph_out_b)) & $past(periph_own_b)) == 0)
      else $error("peripheral data lost");
   a_periph_enable: assert property ($past(rst_n) |-> ((pad_oe_b ^ $past(periph_oe_b)) & $past(periph_own_b)) == 0)
      else $error("peripheral enable lost");
   a_c_unimpl_off: assert property ((pad_oe_c & ~spp_pkg::IMPL_C) == 0) else $error("absent pin driven");
   a_conv_digital: assert property ($past(rst_n) |-> (converter_input_pins & ~$past(pad_in_b)) == 0)
      else $error("converter sees wrong level");
   a_b_reset_input: assert property ($past(rst_n) && !$past(rst_n, 2) && $past(periph_own_b) == 0 |-> pad_oe_b == 0)
      else $error("port b drives after reset");
   a_d_reset_input: assert property ($past(rst_n) && !$past(rst_n, 2) && $past(periph_own_d) == 0 |-> pad_oe_d == 0)
      else $error("port d drives after reset");
   c_read: cover property (reg_read ##1 reg_rdata != 0);
   c_owned: cover property (periph_own_b != 0);
   c_conv: cover property (converter_input_pins != 0);
endmodule : spp_chk
bind spp_ports spp_chk #(.ADDR_W(ADDR_W), .PIN_W(PIN_W)) chk (.clock, .rst_n, .reg_addr, .reg_read, .reg_rdata,
   .pad_in_b, .pad_out_b, .pad_oe_b, .pad_oe_c, .pad_oe_d, .periph_own_b, .periph_out_b, .periph_oe_b,
   .periph_own_d, .converter_input_pins);

// ==== dv/spp_periph.sv ====
// Model of a peripheral sharing one port's pads.
`timescale 1ns/10ps
module spp_periph (
   input  wire logic        clock,
   input  wire logic [15:0] drv_mask,
   input  wire logic [15:0] drv_val,
   input  wire logic [15:0] drv_oe,
   output logic      [15:0] own,
   output logic      [15:0] out = 16'h0000,
   output logic      [15:0] oe = 16'h0000
);
   // Owned pins carry the commanded values; idle pins toggle so that stale data never looks valid.
   always_ff @(posedge clock) begin
      own <= drv_mask;
      out <= (drv_val & drv_mask) | (~out & ~drv_mask);
      oe  <= (drv_oe & drv_mask) | (~oe & ~drv_mask);
   end
endmodule : spp_periph

// ==== dv/spp_ports_test.sv ====
// Self-checking bench for the shared pin port block.
`timescale 1ns/10ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_fail++; $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module spp_ports_test;
   logic        clock = 1'b0, rst_n = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
   logic [15:0] reg_addr = 16'h0000, reg_wdata = 16'h0000, reg_rdata, converter_input_pins;
   logic [15:0] pad_in_b, pad_in_c, pad_in_d, pad_out_b, pad_out_c, pad_out_d, pad_oe_b, pad_oe_c, pad_oe_d;
   logic [15:0] ext_b = 16'hFFFF, ext_c = 16'hFFFF, ext_d = 16'h5A5A, mask_b = 16'h0000, mask_d = 16'h0000;
   logic [15:0] periph_own_b, periph_own_c, periph_own_d, periph_out_b, periph_out_c, periph_out_d;
   logic [15:0] periph_oe_b, periph_oe_c, periph_oe_d, val = 16'h0000, poe = 16'h0000;
   int          n_fail = 0, check_count = 0;
   always #50 clock = ~clock;
   // Each pad shows the driven level where enabled, else the outside level.
   assign pad_in_b = (pad_oe_b & pad_out_b) | (~pad_oe_b & ext_b);
   assign pad_in_c = (pad_oe_c & pad_out_c) | (~pad_oe_c & ext_c);
   assign pad_in_d = (pad_oe_d & pad_out_d) | (~pad_oe_d & ext_d);
   spp_periph PB (.clock, .drv_mask(mask_b), .drv_val(val), .drv_oe(poe), .own(periph_own_b), .out(periph_out_b),
                  .oe(periph_oe_b));
   spp_periph PC (.clock, .drv_mask(mask_b), .drv_val(val), .drv_oe(poe), .own(periph_own_c), .out(periph_out_c),
                  .oe(periph_oe_c));
   spp_periph PD (.clock, .drv_mask(mask_d), .drv_val(val), .drv_oe(poe), .own(periph_own_d), .out(periph_out_d),
                  .oe(periph_oe_d));
   spp_ports DUT (.clock, .rst_n, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .pad_in_b, .pad_in_c,
      .pad_in_d, .pad_out_b, .pad_out_c, .pad_out_d, .pad_oe_b, .pad_oe_c, .pad_oe_d, .periph_own_b, .periph_own_c,
      .periph_own_d, .periph_out_b, .periph_out_c, .periph_out_d, .periph_oe_b, .periph_oe_c, .periph_oe_d,
      .converter_input_pins);
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge clock);
      reg_write <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_write <= 1'b0;
   endtask : wr
   task automatic rd(input logic [15:0] a, input logic [15:0] e);
      @(posedge clock);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_read <= 1'b0;
      #1;
      `CHK(reg_rdata, e)
   endtask : rd
   task automatic st;
      repeat (3) @(posedge clock);
      #1;
   endtask : st
   task automatic finish_test;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : finish_test
   // Main sequence: reset, then each scenario in turn.
   initial begin
      repeat (10) @(posedge clock);
      rst_n <= 1'b1;
      rd(16'h02C6, 16'hFFFF);
      rd(16'h02D2, 16'hFFFF);
      rd(16'h02D6, 16'h0000);
      rd(16'h02CC, 16'hE00A);
      rd(16'h02CE, 16'hE00A);
      rd(16'h02CA, 16'h0000);
      `CHK(pad_oe_b | pad_oe_d, 16'h0000)
      $display("test reset done");
      wr(16'h02D6, 16'hA5C3);
      wr(16'h02D2, 16'h0F0F);
      wr(16'h02CC, 16'h0000);
      wr(16'h02D0, 16'hFFFF);
      st;
      `CHK(pad_oe_d, 16'hF0F0)
      `CHK(pad_out_d, 16'hA5C3)
      `CHK(pad_oe_c, 16'hE00A)
      `CHK(pad_out_c, 16'hE00A)
      rd(16'h02D4, 16'hAACA);
      rd(16'h02D0, 16'hE00A);
      wr(16'h02D4, 16'h1234);
      rd(16'h02D6, 16'h1234);
      $display("test port done");
      @(posedge clock);
      mask_b <= 16'h00FF;
      mask_d <= 16'h00FF;
      val    <= 16'h00AA;
      poe    <= 16'h000F;
      st;
      `CHK(pad_out_d, 16'h12AA)
      `CHK(pad_oe_d, 16'hF00F)
      @(posedge clock);
      mask_b <= 16'h0000;
      mask_d <= 16'h0000;
      st;
      `CHK(pad_out_d, 16'h1234)
      `CHK(pad_oe_d, 16'hF0F0)
      $display("test peripheral done");
      wr(16'h02A8, 16'h00F0);
      wr(16'h02C6, 16'hFF3F);
      wr(16'h02CB, 16'h0040);
      st;
      rd(16'h02C8, 16'hFF4F);
      `CHK(converter_input_pins, 16'h0070)
      `CHK(pad_oe_b, 16'h00C0)
      `CHK(pad_out_b, 16'h0040)
      $display("test analog done");
      finish_test;
   end
   // Watchdog against a hang.
   initial begin
      #400000;
      n_fail++;
      finish_test;
   end
endmodule : spp_ports_test
